// ---- inc/wst_defines.svh ----
// Purpose: constants of the weekly schedule timer
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: times are minutes of the day, 0 to 1439
`ifndef WST_DEFINES_SVH
`define WST_DEFINES_SVH
`define WST_NUM_TIMERS 4
`define WST_NUM_PAUSE 20
`define WST_PAUSE_AW 5
`define WST_PAUSE_W 16
`define WST_TIME_W 11
`define WST_MODE_RUN_BIT 0
`define WST_MODE_FLAG_BIT 1
`define WST_ADR_CTRL 8'h00
`define WST_ADR_STATUS 8'h04
`define WST_TIMER_REGION 2'h1
`define WST_FLD_MODE 2'h0
`define WST_FLD_START 2'h1
`define WST_FLD_END 2'h2
`define WST_FLD_MASK 2'h3
`define WST_PE_EN_BIT 15
`define WST_PE_FMT_BIT 13
`define WST_PE_MON_HI 11
`define WST_PE_MON_LO 8
`define WST_PE_DAY_HI 7
`define WST_PE_DAY_LO 3
`define WST_PE_WD_HI 2
`define WST_PE_WD_LO 0
`define WST_WEEK_FINAL 5'h05
`define WST_SUNDAY 3'h6
`define WST_RST_MODE 2'h0
`define WST_RST_TIME 11'h000
`define WST_RST_MASK 7'h00
`define WST_RST_CTRL 4'h0
`endif

// ---- inc/wst_pkg.sv ----
// Purpose: types of the weekly schedule timer
// Assumes: wst_defines.svh gives the widths
// Notes: none
`include "wst_defines.svh"
package wst_pkg;
  typedef logic [`WST_TIME_W-1:0] wst_time_t;
  typedef logic [1:0] wst_mode_t;
  typedef enum logic [1:0] {WST_IDLE, WST_ADDR, WST_CMP, WST_DONE} wst_state_t;
endpackage

// ---- design/wst_pause_mem.sv ----
// Purpose: storage of the yearly pause dates
// Assumes: one write port, one read port with registered data
// Notes: array itself is cleared by reset
`timescale 1ns/10ps
`default_nettype none
`include "wst_defines.svh"
module wst_pause_mem #(
  parameter int WIDTH = `WST_PAUSE_W,
  parameter int DEPTH = `WST_NUM_PAUSE,
  parameter int AW = `WST_PAUSE_AW
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // cleared so unwritten entries never match a date
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (wr_en_in && (32'(wr_addr_in) < DEPTH)) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else if (32'(rd_addr_in) < DEPTH) begin
      rd_data_out <= mem_reg[rd_addr_in];
    end else begin
      rd_data_out <= '0;
    end
  end
endmodule // wst_pause_mem
`default_nettype wire

// ---- design/wst_timer.sv ----
// Purpose: weekly schedule unit, four timers against the real-time clock
// Assumes: 10 MHz mclk_in, clock and terminal inputs asynchronous
// Notes: outputs change at the end of an evaluation pass, or clear while the clock is disabled
// How it works
// - four timers each have a mode 0 to 3, and mode 0 turns a timer off.
// - mode 1 asks for motor running in the window and raises no flag.
// - mode 2 raises the timer's flags in the window with no run command.
// - mode 3 asks for running and raises the flags in the window.
// - the common active flag is high whenever any timer flag is high.
// - each of the four timers has its own active flag output.
// - four inputs enable the timers one by one and one input cancels all.
// - timers are evaluated only while the clock is enabled.
// - start before end gives a window from start to end on a start day.
// - start not before end runs from start to end time of the next day.
// - a seven-bit mask, Monday at bit 0, marks the start days.
// - twenty yearly pause dates are shared by all timers.
// - on an enabled pause date every timer output is held off.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "wst_defines.svh"
module wst_timer #(
  parameter int NUM_PAUSE = `WST_NUM_PAUSE
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic rtc_enable_in,
  input wire wst_pkg::wst_time_t rtc_minute_of_day_in,
  input wire logic [2:0] rtc_weekday_in,
  input wire logic [3:0] rtc_month_in,
  input wire logic [4:0] rtc_day_in,
  input wire logic timer_one_enable_input_in,
  input wire logic timer_two_enable_input_in,
  input wire logic timer_three_enable_input_in,
  input wire logic timer_four_enable_input_in,
  input wire logic schedule_cancel_input_in,
  output logic motor_run_request_out,
  output logic schedule_active_flag_out,
  output logic timer_one_active_flag_out,
  output logic timer_two_active_flag_out,
  output logic timer_three_active_flag_out,
  output logic timer_four_active_flag_out
);
  import wst_pkg::*;
  localparam int NT = `WST_NUM_TIMERS;
  localparam int PW = 29;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [PW-1:0] pin_s1_reg, pin_s2_reg;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {rtc_enable_in, rtc_minute_of_day_in, rtc_weekday_in,
        rtc_month_in, rtc_day_in, timer_four_enable_input_in,
        timer_three_enable_input_in, timer_two_enable_input_in,
        timer_one_enable_input_in, schedule_cancel_input_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic rtc_en, cancel;
  wst_time_t now;
  logic [2:0] wd;
  logic [3:0] month, en_in;
  logic [4:0] day;
  assign {rtc_en, now, wd, month, day, en_in, cancel} = pin_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register file and bus slave state
  wst_mode_t mode_reg [NT], mode_next [NT];
  wst_time_t start_reg [NT], start_next [NT], end_reg [NT], end_next [NT];
  logic [6:0] mask_reg [NT], mask_next [NT];
  logic [3:0] ctrl_reg, ctrl_next;
  logic ack_reg, ack_next, rd_pend_reg, rd_pend_next;
  logic [31:0] dat_reg, dat_next;
  logic dirty_reg, dirty_next;
  logic [`WST_PAUSE_W-1:0] pause_rdata;
  logic [`WST_PAUSE_AW-1:0] mem_raddr;
  logic mem_we;
  // scan state
  wst_state_t state_reg, state_next;
  logic [`WST_PAUSE_AW-1:0] idx_reg, idx_next;
  logic hit_reg, hit_next, paused_reg, paused_next, run_reg, run_next;
  logic [NT-1:0] flag_reg, flag_next;
  wst_time_t last_min_reg, last_min_next;
  logic [4:0] last_in_reg, last_in_next;
  logic [NT-1:0] act;

  logic wb_req, tmr_sel, pause_sel, full_sel, rd_go, start_scan;
  logic [1:0] tsel, fsel;
  logic [`WST_PAUSE_AW-1:0] pidx;
  assign wb_req = wb_cyc_in && wb_stb_in && !ack_reg && !rd_pend_reg;
  assign tsel = wb_adr_in[5:4];
  assign fsel = wb_adr_in[3:2];
  assign pidx = wb_adr_in[6:2];
  assign tmr_sel = (wb_adr_in[7:6] == `WST_TIMER_REGION);
  assign pause_sel = wb_adr_in[7] && (32'(pidx) < NUM_PAUSE);
  assign full_sel = (wb_sel_in[1:0] == 2'h3);
  assign rd_go = wb_req && !wb_we_in && pause_sel && (state_reg == WST_IDLE);
  assign mem_we = wb_req && wb_we_in && pause_sel && full_sel;
  assign mem_raddr = (state_reg == WST_ADDR) ? idx_reg : pidx;

  always_comb begin
    for (int i = 0; i < NT; i++) begin
      mode_next[i] = mode_reg[i];
      start_next[i] = start_reg[i];
      end_next[i] = end_reg[i];
      mask_next[i] = mask_reg[i];
    end
    ctrl_next = ctrl_reg;
    ack_next = 1'b0;
    rd_pend_next = 1'b0;
    dat_next = dat_reg;
    dirty_next = dirty_reg && !start_scan;
    if (rd_pend_reg) begin
      ack_next = 1'b1;
      dat_next = {16'h0000, pause_rdata};
    end else if (rd_go) begin
      rd_pend_next = 1'b1;
    end else if (wb_req && !(pause_sel && !wb_we_in)) begin
      ack_next = 1'b1;
      dat_next = 32'h0000_0000;
      if (wb_we_in && full_sel) begin
        if (wb_adr_in == `WST_ADR_CTRL) begin
          ctrl_next = wb_dat_in[3:0];
          dirty_next = 1'b1;
        end else if (tmr_sel) begin
          dirty_next = 1'b1;
          case (fsel)
            `WST_FLD_MODE: mode_next[tsel] = wb_dat_in[1:0];
            `WST_FLD_START: start_next[tsel] = wb_dat_in[10:0];
            `WST_FLD_END: end_next[tsel] = wb_dat_in[10:0];
            default: mask_next[tsel] = wb_dat_in[6:0];
          endcase
        end else if (pause_sel) begin
          dirty_next = 1'b1;
        end
      end else if (!wb_we_in) begin
        if (wb_adr_in == `WST_ADR_CTRL) begin
          dat_next = {28'h0000000, ctrl_reg};
        end else if (wb_adr_in == `WST_ADR_STATUS) begin
          dat_next = {24'h000000, rtc_en, (state_reg != WST_IDLE),
            paused_reg, run_reg, flag_reg};
        end else if (tmr_sel) begin
          case (fsel)
            `WST_FLD_MODE: dat_next = {30'h0, mode_reg[tsel]};
            `WST_FLD_START: dat_next = {21'h0, start_reg[tsel]};
            `WST_FLD_END: dat_next = {21'h0, end_reg[tsel]};
            default: dat_next = {25'h0, mask_reg[tsel]};
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NT; i++) begin
        mode_reg[i] <= `WST_RST_MODE;
        start_reg[i] <= `WST_RST_TIME;
        end_reg[i] <= `WST_RST_TIME;
        mask_reg[i] <= `WST_RST_MASK;
      end
      ctrl_reg <= `WST_RST_CTRL;
      ack_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      dirty_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      start_reg <= start_next;
      end_reg <= end_next;
      mask_reg <= mask_next;
      ctrl_reg <= ctrl_next;
      ack_reg <= ack_next;
      rd_pend_reg <= rd_pend_next;
      dat_reg <= dat_next;
      dirty_reg <= dirty_next;
    end
  end
  assign wb_ack_out = ack_reg;
  assign wb_dat_out = dat_reg;

  wst_pause_mem #(.DEPTH(NUM_PAUSE)) u_pause_mem (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(mem_we),
    .wr_addr_in(pidx),
    .wr_data_in(wb_dat_in[15:0]),
    .rd_addr_in(mem_raddr),
    .rd_data_out(pause_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // window of each timer
  logic [2:0] prev_wd;
  assign prev_wd = (wd == 3'h0) ? `WST_SUNDAY : wd - 3'h1;
  for (genvar g = 0; g < NT; g++) begin : g_win
    logic [7:0] m;
    logic after_start, before_end, win, gate;
    assign m = {1'b0, mask_reg[g]};
    assign after_start = (now >= start_reg[g]);
    assign before_end = (now < end_reg[g]);
    assign win = (start_reg[g] < end_reg[g]) ?
      (m[wd] && after_start && before_end) :
      ((m[wd] && after_start) || (m[prev_wd] && before_end));
    assign gate = !cancel && (!ctrl_reg[g] || en_in[g]);
    assign act[g] = win && gate && (mode_reg[g] != `WST_RST_MODE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // pause date match
  function automatic logic pause_match(input logic [15:0] e);
    logic [4:0] wk, dim;
    wk = (day <= 5'd7) ? 5'd1 : (day <= 5'd14) ? 5'd2 :
      (day <= 5'd21) ? 5'd3 : (day <= 5'd28) ? 5'd4 : `WST_WEEK_FINAL;
    case (month)
      4'h2: dim = 5'd28;
      4'h4, 4'h6, 4'h9, 4'hb: dim = 5'd30;
      default: dim = 5'd31;
    endcase
    if (!e[`WST_PE_EN_BIT] ||
        e[`WST_PE_MON_HI:`WST_PE_MON_LO] != month) begin
      pause_match = 1'b0;
    end else if (e[`WST_PE_FMT_BIT]) begin
      pause_match = (e[`WST_PE_DAY_HI:`WST_PE_DAY_LO] == day);
    end else if (e[`WST_PE_WD_HI:`WST_PE_WD_LO] != wd) begin
      pause_match = 1'b0;
    end else if (e[`WST_PE_DAY_HI:`WST_PE_DAY_LO] == `WST_WEEK_FINAL) begin
      pause_match = (6'(day) + 6'd7 > 6'(dim));
    end else begin
      pause_match = (e[`WST_PE_DAY_HI:`WST_PE_DAY_LO] == wk);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // evaluation pass
  logic trigger;
  assign trigger = rtc_en && (now != last_min_reg || dirty_reg ||
    {en_in, cancel} != last_in_reg);
  assign start_scan = (state_reg == WST_IDLE) && trigger && !rd_go &&
    !rd_pend_reg;

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    hit_next = hit_reg;
    paused_next = paused_reg;
    flag_next = flag_reg;
    run_next = run_reg;
    last_min_next = last_min_reg;
    last_in_next = last_in_reg;
    case (state_reg)
      WST_IDLE: begin
        if (!rtc_en) begin
          flag_next = '0;
          run_next = 1'b0;
        end else if (start_scan) begin
          last_min_next = now;
          last_in_next = {en_in, cancel};
          idx_next = '0;
          hit_next = 1'b0;
          state_next = WST_ADDR;
        end
      end
      WST_ADDR: state_next = WST_CMP;
      WST_CMP: begin
        if (pause_match(pause_rdata)) begin
          hit_next = 1'b1;
        end
        if (32'(idx_reg) == NUM_PAUSE - 1) begin
          state_next = WST_DONE;
        end else begin
          idx_next = idx_reg + 5'h01;
          state_next = WST_ADDR;
        end
      end
      WST_DONE: begin
        paused_next = hit_reg;
        for (int i = 0; i < NT; i++) begin
          flag_next[i] = !hit_reg && act[i] &&
            mode_reg[i][`WST_MODE_FLAG_BIT];
        end
        run_next = 1'b0;
        for (int i = 0; i < NT; i++) begin
          if (!hit_reg && act[i] && mode_reg[i][`WST_MODE_RUN_BIT]) begin
            run_next = 1'b1;
          end
        end
        state_next = WST_IDLE;
      end
      default: state_next = WST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= WST_IDLE;
      idx_reg <= '0;
      hit_reg <= 1'b0;
      paused_reg <= 1'b0;
      flag_reg <= '0;
      run_reg <= 1'b0;
      last_min_reg <= `WST_RST_TIME;
      last_in_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      hit_reg <= hit_next;
      paused_reg <= paused_next;
      flag_reg <= flag_next;
      run_reg <= run_next;
      last_min_reg <= last_min_next;
      last_in_reg <= last_in_next;
    end
  end

  assign motor_run_request_out = run_reg;
  assign schedule_active_flag_out = |flag_reg;
  assign {timer_four_active_flag_out, timer_three_active_flag_out,
    timer_two_active_flag_out, timer_one_active_flag_out} = flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic done;
  assign done = (state_reg == WST_DONE);
  AST_MODE0_OFF: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    done && mode_reg[0] == 2'h0 |=> !flag_reg[0])
    else $error("disabled timer raised its flag");
  AST_MODE1_NOFLAG: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    done && mode_reg[0] == 2'h1 |=>
    !flag_reg[0] && (run_reg || !$past(act[0] && !hit_reg)))
    else $error("mode 1 timer misbehaved");
  AST_MODE2_FLAG: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    done && mode_reg[0] == 2'h2 && act[0] && !hit_reg |=> flag_reg[0])
    else $error("mode 2 timer gave no flag");
  AST_MODE3_BOTH: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    done && mode_reg[0] == 2'h3 && act[0] && !hit_reg |=> flag_reg[0] && run_reg)
    else $error("mode 3 timer missed run or flag");
  AST_COMMON_FLAG: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    schedule_active_flag_out == (timer_one_active_flag_out ||
    timer_two_active_flag_out || timer_three_active_flag_out ||
    timer_four_active_flag_out))
    else $error("common flag disagrees with timer flags");
  AST_CANCEL: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    done && cancel |=> flag_reg == 4'h0 && !run_reg)
    else $error("cancel did not stop the timers");
  AST_RTC_OFF: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state_reg == WST_IDLE && !rtc_en |=> flag_reg == 4'h0 && !run_reg)
    else $error("outputs active with clock disabled");
  AST_PAUSE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    done && hit_reg |=> flag_reg == 4'h0 && !run_reg && paused_reg)
    else $error("pause date did not hold timers off");
  AST_MINUTE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start_scan |=> ##[1:45] done)
    else $error("evaluation pass did not finish");
endmodule // wst_timer
`default_nettype wire

// ---- tb/wst_rtc_model.sv ----
// Purpose: real-time clock partner of the schedule unit
// Assumes: values load on each edge while enabled
// Notes: disabled clock shows a toggling pattern, not held values
`timescale 1ns/10ps
`default_nettype none
module wst_rtc_model (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  input wire wst_pkg::wst_time_t min_in,
  input wire logic [2:0] wd_in,
  input wire logic [3:0] mon_in,
  input wire logic [4:0] day_in,
  output logic en_out,
  output wst_pkg::wst_time_t min_out,
  output logic [2:0] wd_out,
  output logic [3:0] mon_out,
  output logic [4:0] day_out
);
  import wst_pkg::*;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_out <= 1'b0;
      min_out <= 11'h000;
      wd_out <= 3'h0;
      mon_out <= 4'h0;
      day_out <= 5'h00;
    end else begin
      en_out <= en_in;
      // stopped clock: date and time are meaningless
      min_out <= en_in ? min_in : ~min_out;
      wd_out <= en_in ? wd_in : ~wd_out;
      mon_out <= en_in ? mon_in : ~mon_out;
      day_out <= en_in ? day_in : ~day_out;
    end
  end
endmodule // wst_rtc_model
`default_nettype wire

// ---- tb/weekly_schedule_timer_tb.sv ----
// Purpose: self-checking bench of the weekly schedule unit
// Assumes: status at 0x04, timers from 0x40, pause entries from 0x80
// Notes: outputs judged 100 cycles after each change of inputs
`timescale 1ns/10ps
`default_nettype none
module weekly_schedule_timer_tb;
  import wst_pkg::*;
  logic mclk_in = 0, rst_n_in = 0, req = 0, we = 0, ack, run, act;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0, ten = 0, fl, ctl = 0;
  logic [31:0] dat = 0, rdq, wdo;
  logic ren = 0, cancel = 0, pz = 0, r_en;
  wst_time_t rmin = 0, r_min, s, e;
  logic [2:0] rwd = 0, r_wd;
  logic [3:0] rmon = 4'h1, r_mon;
  logic [4:0] rday = 5'h01, r_day;
  wst_mode_t md [4];
  wst_time_t st [4], et [4];
  logic [6:0] mk [4];
  logic [15:0] lf = 16'h2e58;
  int mismatches = 0, n_checks = 0, i, j;
  always #50 mclk_in = ~mclk_in;
  wst_rtc_model rtc (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .en_in(ren), .min_in(rmin), .wd_in(rwd), .mon_in(rmon),
    .day_in(rday), .en_out(r_en), .min_out(r_min), .wd_out(r_wd),
    .mon_out(r_mon), .day_out(r_day));
  wst_timer dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(req), .wb_stb_in(req), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(wdo),
    .wb_ack_out(ack), .rtc_enable_in(r_en),
    .rtc_minute_of_day_in(r_min), .rtc_weekday_in(r_wd),
    .rtc_month_in(r_mon), .rtc_day_in(r_day),
    .timer_one_enable_input_in(ten[0]),
    .timer_two_enable_input_in(ten[1]),
    .timer_three_enable_input_in(ten[2]),
    .timer_four_enable_input_in(ten[3]),
    .schedule_cancel_input_in(cancel), .motor_run_request_out(run),
    .schedule_active_flag_out(act), .timer_one_active_flag_out(fl[0]),
    .timer_two_active_flag_out(fl[1]),
    .timer_three_active_flag_out(fl[2]),
    .timer_four_active_flag_out(fl[3]));
  //////////////////////////////////////////////////////////////////////
  function automatic int rnd(input int m);
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return int'(lf) % m;
  endfunction
  function automatic logic win(input wst_time_t a, b, n,
    input logic [6:0] k, input logic [2:0] w);
    logic [2:0] p;
    p = (w == 3'h0) ? 3'h6 : w - 3'h1;
    if (a < b) return k[w] && n >= a && n < b;
    return (k[w] && n >= a) || (k[p] && n < b);
  endfunction
  task close_out;
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %0t got %h want %h", $time, g, x);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] sl);
    int n;
    @(posedge mclk_in);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= sl;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk_in);
      if (ack === 1'b1) break;
    end
    if (n == 200) begin
      mismatches++;
      $display("mismatch %0t no bus answer", $time);
      close_out;
    end
    rdq = wdo;
    req <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask
  task cfg(input int t, input wst_mode_t m, input wst_time_t a, b,
    input logic [6:0] k);
    logic [7:0] o;
    o = 8'h40 + 8'(t * 16);
    wr(o, 32'(m));
    wr(o + 8'h4, 32'(a));
    wr(o + 8'h8, 32'(b));
    wr(o + 8'hc, 32'(k));
    rd(o + 8'hc);
    chk(rdq, 32'(k));
    md[t] = m;
    st[t] = a;
    et[t] = b;
    mk[t] = k;
  endtask
  task evl;
    logic [5:0] x;
    logic a;
    int t;
    // sync flops plus one full pass
    // a pass already running can delay the next one
    repeat (100) @(posedge mclk_in);
    x = 6'h00;
    for (t = 0; t < 4; t++) begin
      a = ren && !cancel && !pz && (!ctl[t] || ten[t]);
      a = a && win(st[t], et[t], rmin, mk[t], rwd);
      x[t] = a && md[t][1];
      x[4] = x[4] | (a && md[t][0]);
    end
    x[5] = |x[3:0];
    chk(32'({act, run, fl}), 32'(x));
    rd(8'h04);
    chk(32'(rdq[4:0]), 32'(x[4:0]));
  endtask
  task go(input logic [2:0] w, input wst_time_t m);
    rwd <= w;
    rmin <= m;
    evl;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge mclk_in);
    mismatches++;
    $display("mismatch %0t run too long", $time);
    close_out;
  end
  initial begin
    for (i = 0; i < 4; i++) begin
      md[i] = 2'h0;
      st[i] = 11'h000;
      et[i] = 11'h000;
      mk[i] = 7'h00;
    end
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    chk(32'({act, run, fl}), 32'h0);
    for (i = 0; i < 16; i++) begin
      rd(8'h40 + 8'(i * 4));
      chk(rdq, 32'h0);
    end
    rd(8'h3c);
    chk(rdq, 32'h0);
    ren <= 1'b1;
    go(3'h2, 11'd600);
    for (j = 0; j < 4; j++) begin
      for (i = 0; i < 4; i++) cfg(i, 2'(j), 11'd500, 11'd700, 7'h04);
      evl;
    end
    cfg(0, 2'h3, 11'd1380, 11'd120, 7'h40);
    cfg(1, 2'h2, 11'd300, 11'd300, 7'h01);
    cfg(2, 2'h1, 11'd500, 11'd700, 7'h02);
    cfg(3, 2'h0, 11'd0, 11'd1439, 7'h7f);
    go(3'h0, 11'd60);
    go(3'h0, 11'd120);
    go(3'h6, 11'd1379);
    go(3'h6, 11'd1380);
    go(3'h1, 11'd299);
    go(3'h1, 11'd300);
    go(3'h1, 11'd500);
    go(3'h1, 11'd699);
    go(3'h1, 11'd700);
    wb(1'b1, 8'h70, 32'h3, 4'h0);
    rd(8'h70);
    chk(rdq, 32'h0);
    cfg(3, 2'h3, 11'd0, 11'd1439, 7'h7f);
    ctl = 4'hf;
    wr(8'h00, 32'hf);
    ten <= 4'h5;
    go(3'h1, 11'd600);
    cancel <= 1'b1;
    evl;
    cancel <= 1'b0;
    wr(8'hcc, 32'h0000a720);
    rd(8'hcc);
    chk(rdq, 32'h0000a720);
    wr(8'h80, 32'h00008312);
    rmon <= 4'h7;
    rday <= 5'h04;
    pz = 1'b1;
    evl;
    rmon <= 4'h3;
    rday <= 5'h0a;
    go(3'h2, 11'd601);
    pz = 1'b0;
    rday <= 5'h11;
    evl;
    ren <= 1'b0;
    evl;
    ren <= 1'b1;
    ctl = 4'h5;
    wr(8'h00, 32'h5);
    for (i = 0; i < 40; i++) begin
      s = 11'(rnd(1440));
      e = (rnd(8) == 0) ? s : 11'(rnd(1440));
      cfg(rnd(4), 2'(rnd(4)), s, e, 7'(rnd(128)));
      ten <= 4'(rnd(16));
      go(3'(rnd(7)), 11'(rnd(1440)));
    end
    close_out;
  end
endmodule // weekly_schedule_timer_tb
`default_nettype wire
